// File: design/l2cmc_top.sv
// Cache control register and the second-level cache behaviour it governs
//
// Contract
// R01 - Bit 3 set suppresses the pipelining request
// R02 - Software sets pipelining bit before caches
// R03 - Request line rewired only while bit 3 set
// R04 - Force-miss makes every tag lookup miss
// R05 - Force-miss with L2 enabled: cycle misses
// R06 - FIRST_LEVEL_CACHE_ENABLE 0, force-miss 1: reads invalidate tag
// R07 - FIRST_LEVEL_CACHE_ENABLE 1, force-miss 0: normal hit detection
// R08 - Flush: force-miss, read tags, write back dirty
// R09 - L2 enabled needs size nonzero and FIRST_LEVEL_CACHE_ENABLE
// R10 - FIRST_LEVEL_CACHE_ENABLE 1: cache-enable on cacheable cycles
// R11 - FIRST_LEVEL_CACHE_ENABLE 0: cache-enable negated, no fills
// R12 - Both set: writes miss too, incoherence possible
// R13 - Reserved bit 2 reads zero, no effect
`timescale 1ns/1ps
`default_nettype none
module l2cmc_top
    import l2cmc_pkg::*;
(
    // Clock and reset
    input  wire logic              mclk_in,
    input  wire logic              resetn_in,
    // Register port
    input  wire logic [ADDR_W-1:0] reg_addr_in,
    input  wire logic [DATA_W-1:0] reg_wdata_in,
    input  wire logic              reg_wr_in,
    input  wire logic              reg_rd_in,
    output logic      [DATA_W-1:0] reg_rdata_out,
    // Processor cycle, from pins
    input  wire logic              cyc_valid_in,
    input  wire logic              cyc_write_in,
    input  wire logic              cyc_cacheable_in,
    input  wire logic              na_wanted_in,
    // External tag compare, from pins
    input  wire logic              tag_match_in,
    input  wire logic              tag_valid_in,
    input  wire logic              tag_dirty_in,
    // Processor side outputs
    output logic                   cache_enable_indication_n_out,
    output logic                   next_address_request_n_out,
    // Cache side outputs
    output logic                   l2_hit_out,
    output logic                   l2_miss_out,
    output logic                   line_fill_out,
    output logic                   tag_invalidate_out,
    output logic                   writeback_out
);

    // Two-stage synchronisers for all pin inputs
    localparam int NSYNC = 7;
    logic [NSYNC-1:0] sync1_r;
    logic [NSYNC-1:0] sync2_r;

    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= {cyc_valid_in, cyc_write_in, cyc_cacheable_in,
                        na_wanted_in, tag_match_in, tag_valid_in,
                        tag_dirty_in};
            sync2_r <= sync1_r;
        end
    end

    logic s_valid;
    logic s_write;
    logic s_cacheable;
    logic s_na;
    logic s_match;
    logic s_tvalid;
    logic s_dirty;
    assign {s_valid, s_write, s_cacheable, s_na,
            s_match, s_tvalid, s_dirty} = sync2_r;

    // Register file
    logic [7:0]       cache_control_r;
    logic [7:0]       cache_control_nxt;
    logic [CNT_W-1:0] wb_cnt_r;
    logic [CNT_W-1:0] inv_cnt_r;
    logic             incoh_r;
    logic             wb_seen_r;

    // Unwritable reserved bit stays zero
    always_comb begin
        cache_control_nxt = cache_control_r;
        if (reg_wr_in && reg_addr_in == CACHE_CTL_OFF) begin
            // R13 reserved bit masked
            cache_control_nxt = reg_wdata_in & CTL_WMASK;
        end
    end

    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cache_control_r <= CTL_RESET;
        end else begin
            cache_control_r <= cache_control_nxt;
        end
    end

    logic       first_level_cache_enable;
    logic       fmi;
    logic       na_dis;
    logic [1:0] size_sel;
    assign first_level_cache_enable     = cache_control_r[FIRST_LEVEL_CACHE_ENABLE_BIT];
    assign fmi      = cache_control_r[FMI_BIT];
    assign na_dis   = cache_control_r[NA_DIS_BIT];
    assign size_sel = cache_control_r[SIZE_LSB +: 2];

    // R09 enable needs size and FIRST_LEVEL_CACHE_ENABLE
    logic l2_en;
    assign l2_en = (size_sel != SIZE_NONE) && first_level_cache_enable;

    // Cache populated means a nonzero size is fitted
    logic l2_present;
    assign l2_present = (size_sel != SIZE_NONE);

    logic flushing;
    assign flushing = l2_en && fmi;

    // Lookup decision
    l2cmc_res_t res;
    logic       fill;
    logic       inval;
    logic       wback;

    always_comb begin
        res   = L2CMC_IDLE;
        fill  = 1'b0;
        inval = 1'b0;
        wback = 1'b0;
        if (s_valid && l2_present) begin
            if (fmi) begin
                // R04 force-miss always misses
                res = L2CMC_MISS;
            end else if (l2_en && s_match && s_tvalid) begin
                // R07 normal hit detection
                res = L2CMC_HIT;
            end else begin
                res = L2CMC_MISS;
            end
            // R06 reads invalidate selected tag
            if (!first_level_cache_enable && fmi && !s_write) begin
                inval = 1'b1;
            end
            // R08 flush writes back dirty lines
            if (flushing && !s_write && s_tvalid && s_dirty) begin
                wback = 1'b1;
            end
            // R11 no fills without FIRST_LEVEL_CACHE_ENABLE
            // R05 forced misses never allocate
            if (l2_en && !fmi && res == L2CMC_MISS
                && !s_write && s_cacheable) begin
                fill = 1'b1;
            end
        end
    end

    // Output flops
    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            l2_hit_out         <= 1'b0;
            l2_miss_out        <= 1'b0;
            line_fill_out      <= 1'b0;
            tag_invalidate_out <= 1'b0;
            writeback_out      <= 1'b0;
        end else begin
            l2_hit_out         <= (res == L2CMC_HIT);
            l2_miss_out        <= (res == L2CMC_MISS);
            line_fill_out      <= fill;
            tag_invalidate_out <= inval;
            writeback_out      <= wback;
        end
    end

    // R10 cache-enable on cacheable cycles
    // R11 negated whenever FIRST_LEVEL_CACHE_ENABLE is clear
    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cache_enable_indication_n_out <= 1'b1;
        end else begin
            cache_enable_indication_n_out <=
                !(first_level_cache_enable && s_valid && s_cacheable);
        end
    end

    // R01 disable bit suppresses request
    // R03 safe to rewire once disabled
    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            next_address_request_n_out <= 1'b1;
        end else begin
            next_address_request_n_out <= !(s_na && !na_dis);
        end
    end

    // R12 writes forced to miss, may go incoherent
    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            incoh_r <= 1'b0;
        end else if (reg_wr_in && reg_addr_in == STATUS_OFF
                     && reg_wdata_in[ST_INCOH_BIT]) begin
            // Set wins over a same-cycle clear
            incoh_r <= first_level_cache_enable && fmi && s_valid && s_write && l2_present;
        end else if (first_level_cache_enable && fmi && s_valid && s_write && l2_present) begin
            incoh_r <= 1'b1;
        end
    end

    // Activity counters for flush write-backs and tag invalidations
    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            wb_cnt_r  <= '0;
            wb_seen_r <= 1'b0;
        end else if (wback) begin
            wb_cnt_r  <= wb_cnt_r + 1'b1;
            wb_seen_r <= 1'b1;
        end else if (!flushing) begin
            wb_seen_r <= 1'b0;
        end
    end

    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            inv_cnt_r <= '0;
        end else if (inval) begin
            inv_cnt_r <= inv_cnt_r + 1'b1;
        end
    end

    // Read mux splits each counter into exactly two bytes
    if (CNT_W != 16 || DATA_W != 8) begin : g_bad_width
        $error("counter must be 16 bits and data 8 bits");
    end

    // Read path, data one cycle after the strobe
    function automatic logic [7:0] rd_mux(input logic [7:0] a);
        logic [7:0] st;
        st = 8'h00;
        st[ST_L2EN_BIT]  = l2_en;
        st[ST_FLUSH_BIT] = flushing;
        st[ST_WB_BIT]    = wb_seen_r;
        st[ST_INCOH_BIT] = incoh_r;
        case (a)
            CACHE_CTL_OFF:  rd_mux = cache_control_r;
            STATUS_OFF:     rd_mux = st;
            WB_CNT_LO_OFF:  rd_mux = wb_cnt_r[7:0];
            WB_CNT_HI_OFF:  rd_mux = wb_cnt_r[15:8];
            INV_CNT_LO_OFF: rd_mux = inv_cnt_r[7:0];
            INV_CNT_HI_OFF: rd_mux = inv_cnt_r[15:8];
            default:        rd_mux = 8'h00;
        endcase
    endfunction

    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            reg_rdata_out <= 8'h00;
        end else if (reg_rd_in) begin
            reg_rdata_out <= rd_mux(reg_addr_in);
        end else begin
            reg_rdata_out <= 8'h00;
        end
    end

    // Checks
    chk_na_suppress: assert property ( // R01
        @(posedge mclk_in) disable iff (!resetn_in)
        $past(na_dis) |-> next_address_request_n_out)
        else $error("pipelining request asserted while disabled");

    chk_force_miss: assert property ( // R04
        @(posedge mclk_in) disable iff (!resetn_in)
        (s_valid && l2_present && fmi) |=> (l2_miss_out && !l2_hit_out))
        else $error("forced lookup did not miss");

    chk_forced_no_fill: assert property ( // R05
        @(posedge mclk_in) disable iff (!resetn_in)
        (l2_en && fmi) |=> !line_fill_out)
        else $error("fill during forced miss");

    chk_read_inval: assert property ( // R06
        @(posedge mclk_in) disable iff (!resetn_in)
        (s_valid && l2_present && !first_level_cache_enable && fmi && !s_write)
        |=> tag_invalidate_out)
        else $error("read did not invalidate tag");

    chk_normal_hit: assert property ( // R07
        @(posedge mclk_in) disable iff (!resetn_in)
        (s_valid && l2_en && !fmi && s_match && s_tvalid)
        |=> l2_hit_out)
        else $error("matching tag not reported as hit");

    chk_flush_wback: assert property ( // R08
        @(posedge mclk_in) disable iff (!resetn_in)
        (s_valid && flushing && !s_write && s_tvalid && s_dirty)
        |=> writeback_out && $changed(wb_cnt_r))
        else $error("dirty line not written back during flush");

    chk_l2_enable: assert property ( // R09
        @(posedge mclk_in) disable iff (!resetn_in)
        line_fill_out |-> $past(first_level_cache_enable) && ($past(size_sel) != SIZE_NONE))
        else $error("fill with cache not enabled");

    chk_ken_assert: assert property ( // R10
        @(posedge mclk_in) disable iff (!resetn_in)
        (first_level_cache_enable && s_valid && s_cacheable) |=> !cache_enable_indication_n_out)
        else $error("cache-enable not given");

    chk_ken_negated: assert property ( // R11
        @(posedge mclk_in) disable iff (!resetn_in)
        !first_level_cache_enable |=> cache_enable_indication_n_out && !line_fill_out)
        else $error("cache-enable or fill with FIRST_LEVEL_CACHE_ENABLE clear");

    chk_write_miss: assert property ( // R12
        @(posedge mclk_in) disable iff (!resetn_in)
        (s_valid && l2_present && first_level_cache_enable && fmi && s_write)
        |=> l2_miss_out && incoh_r)
        else $error("write not forced to miss");

    chk_reserved_zero: assert property ( // R13
        @(posedge mclk_in) disable iff (!resetn_in)
        reg_rd_in && reg_addr_in == CACHE_CTL_OFF
        |=> !reg_rdata_out[RSVD_BIT])
        else $error("reserved bit reads nonzero");

    chk_na_given: assert property ( // R01
        @(posedge mclk_in) disable iff (!resetn_in)
        (s_na && !na_dis) |=> !next_address_request_n_out)
        else $error("pipelining request withheld while enabled");

    chk_cacheless_quiet: assert property ( // R09
        @(posedge mclk_in) disable iff (!resetn_in)
        (s_valid && !l2_present) |=> !(l2_hit_out || l2_miss_out || line_fill_out
                                       || tag_invalidate_out || writeback_out))
        else $error("lookup activity with no cache fitted");

    chk_ken_idle: assert property ( // R10
        @(posedge mclk_in) disable iff (!resetn_in)
        !(first_level_cache_enable && s_valid && s_cacheable) |=> cache_enable_indication_n_out)
        else $error("cache-enable outside a cacheable cycle");

    chk_reserved_store: assert property ( // R13
        @(posedge mclk_in) disable iff (!resetn_in)
        !cache_control_r[RSVD_BIT])
        else $error("reserved bit stored");

endmodule : l2cmc_top
`default_nettype wire

// File: design/l2cmc_pkg.sv
// Constants for the second-level cache mode control block
package l2cmc_pkg;
    localparam int          ADDR_W        = 8;
    localparam int          DATA_W        = 8;
    localparam int          CNT_W         = 16;
    // Register offsets
    localparam logic [7:0]  CACHE_CTL_OFF = 8'h00;
    localparam logic [7:0]  STATUS_OFF    = 8'h04;
    localparam logic [7:0]  WB_CNT_LO_OFF = 8'h08;
    localparam logic [7:0]  WB_CNT_HI_OFF = 8'h09;
    localparam logic [7:0]  INV_CNT_LO_OFF = 8'h0a;
    localparam logic [7:0]  INV_CNT_HI_OFF = 8'h0b;
    // Field positions of cache_control
    localparam int          FIRST_LEVEL_CACHE_ENABLE_BIT      = 0;
    localparam int          FMI_BIT       = 1;
    localparam int          RSVD_BIT      = 2;
    localparam int          NA_DIS_BIT    = 3;
    localparam int          SRAMT_LSB     = 4;
    localparam int          SIZE_LSB      = 6;
    // Writable bits; reserved bit 2 masked out
    localparam logic [7:0]  CTL_WMASK     = 8'hfb;
    localparam logic [7:0]  CTL_RESET     = 8'h00;
    localparam logic [1:0]  SIZE_NONE     = 2'h0;
    // Status register bit positions
    localparam int          ST_L2EN_BIT   = 0;
    localparam int          ST_FLUSH_BIT  = 1;
    localparam int          ST_WB_BIT     = 2;
    localparam int          ST_INCOH_BIT  = 3;
    // Outcome of a lookup
    typedef enum logic [1:0] {
        L2CMC_IDLE,
        L2CMC_HIT,
        L2CMC_MISS
    } l2cmc_res_t;
endpackage : l2cmc_pkg

// File: tb/l2cmc_cpu_model.sv
// Host processor model driving the cycle and pipelining pins
`timescale 1ns/1ps
`default_nettype none
module l2cmc_cpu_model (
    // Clock and reset
    input  wire logic mclk_in,
    input  wire logic resetn_in,
    // Commands from the bench
    input  wire logic go_in,
    input  wire logic wr_in,
    input  wire logic cach_in,
    input  wire logic na_in,
    input  wire logic attach_in,
    // Pins toward the controller
    output logic      cyc_valid_out,
    output logic      cyc_write_out,
    output logic      cyc_cacheable_out,
    output logic      na_wanted_out
);
    // Qualifiers toggle while idle so stale values are never trusted
    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cyc_valid_out     <= 1'b0;
            cyc_write_out     <= 1'b0;
            cyc_cacheable_out <= 1'b0;
        end else begin
            cyc_valid_out     <= go_in;
            cyc_write_out     <= go_in ? wr_in : ~cyc_write_out;
            cyc_cacheable_out <= go_in ? cach_in : ~cyc_cacheable_out;
        end
    end
    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            na_wanted_out <= 1'b0;
        end else begin
            na_wanted_out <= na_in & attach_in;
        end
    end
endmodule // l2cmc_cpu_model
`default_nettype wire

// File: tb/tb_top.sv
// Self-checking bench for the cache mode control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin bad_count++; \
    $display("unexpected %s expected %h seen %h", n, e, g); end end
module tb_top;
    import l2cmc_pkg::*;
    logic        mclk_in = 0, resetn_in = 0, wr = 0, rd = 0, go = 0, cwr = 0, cca = 0;
    logic        na = 0, att = 0, tm = 0, tv = 0, td = 0, incoh = 0, wbseen = 0, fl, en, kseen, w, c;
    logic [7:0]  addr = 0, wdata = 0, rdata, k, rv, cnt;
    logic        cv, cw, cc, naw, ken_n, na_n, hit, miss, fill, inv, wb;
    logic [4:0]  e, got;
    logic [15:0] wbn = 0, invn = 0;
    logic [31:0] seed = 32'h0000e569, r;
    logic [7:0]  tab [6] = '{8'h41, 8'h43, 8'h42, 8'h40, 8'h01, 8'h03};
    int          bad_count = 0, check_count = 0, cycles = 0;
    l2cmc_cpu_model cpu (.mclk_in(mclk_in), .resetn_in(resetn_in), .go_in(go), .wr_in(cwr), .cach_in(cca),
        .na_in(na), .attach_in(att), .cyc_valid_out(cv), .cyc_write_out(cw), .cyc_cacheable_out(cc),
        .na_wanted_out(naw));
    l2cmc_top uut (.mclk_in(mclk_in), .resetn_in(resetn_in), .reg_addr_in(addr), .reg_wdata_in(wdata),
        .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .cyc_valid_in(cv), .cyc_write_in(cw),
        .cyc_cacheable_in(cc), .na_wanted_in(naw), .tag_match_in(tm), .tag_valid_in(tv), .tag_dirty_in(td),
        .cache_enable_indication_n_out(ken_n), .next_address_request_n_out(na_n), .l2_hit_out(hit),
        .l2_miss_out(miss), .line_fill_out(fill), .tag_invalidate_out(inv), .writeback_out(wb));
    always #5 mclk_in = ~mclk_in;
    task automatic results();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Lookups plus register traffic stay far below this ceiling
    always @(posedge mclk_in) begin
        cycles++;
        if (cycles == 30000) begin
            bad_count++;
            results();
        end
    end
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [4:0] exp_f(input logic [7:0] v, input logic w, c, m, tvl, d);
        logic lk, le, h, mi;
        lk = v[7:6] != SIZE_NONE;
        le = lk && v[FIRST_LEVEL_CACHE_ENABLE_BIT];
        h  = le && !v[FMI_BIT] && m && tvl;
        mi = lk && !h;
        return {h, mi, mi && le && !v[FMI_BIT] && c && !w, lk && !v[FIRST_LEVEL_CACHE_ENABLE_BIT] && v[FMI_BIT] && !w,
                le && v[FMI_BIT] && !w && tvl && d};
    endfunction
    task automatic wr_reg(input logic [7:0] a, d);
        @(posedge mclk_in) begin wr <= 1; addr <= a; wdata <= d; end
        @(posedge mclk_in) wr <= 0;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
        @(posedge mclk_in) begin rd <= 1; addr <= a; end
        @(posedge mclk_in) rd <= 0;
        @(negedge mclk_in) v = rdata;
    endtask
    // One lookup; pulses are counted over a window wider than the pin latency
    task automatic lookup(input logic w, c);
        @(posedge mclk_in) begin go <= 1; cwr <= w; cca <= c; end
        @(posedge mclk_in) go <= 0;
        got = 0; cnt = 0; kseen = 0;
        repeat (8) @(negedge mclk_in) begin
            got = got | {hit, miss, fill, inv, wb};
            cnt = cnt + 8'(hit) + 8'(miss) + 8'(fill) + 8'(inv) + 8'(wb);
            kseen = kseen | !ken_n;
        end
    endtask
    initial begin
        repeat (16) @(posedge mclk_in);
        resetn_in <= 1;
        rd_reg(CACHE_CTL_OFF, rv); `CHK("ctl reset", CTL_RESET, rv)
        rd_reg(STATUS_OFF, rv); `CHK("status reset", 8'h00, rv)
        wr_reg(CACHE_CTL_OFF, 8'hff);
        rd_reg(CACHE_CTL_OFF, rv); `CHK("ctl reserved", 8'hfb, rv)
        wr_reg(8'h10, 8'h55);
        rd_reg(8'h10, rv); `CHK("unmapped", 8'h00, rv)
        // disable programmed before caches; attach only under disable
        wr_reg(CACHE_CTL_OFF, 8'h08);
        @(posedge mclk_in) begin att <= 1; na <= 1; end
        repeat (8) @(posedge mclk_in);
        `CHK("na disabled", 1'b1, na_n)
        wr_reg(CACHE_CTL_OFF, 8'h00);
        repeat (8) @(posedge mclk_in);
        `CHK("na enabled", 1'b0, na_n)
        @(posedge mclk_in) na <= 0;
        repeat (8) @(posedge mclk_in);
        `CHK("na idle", 1'b1, na_n)
        for (int i = 0; i < 46; i++) begin
            r = rnd();
            k = (i < 6) ? tab[i] : r[15:8];
            wr_reg(CACHE_CTL_OFF, k);
            en = (k[7:6] != SIZE_NONE) && k[FIRST_LEVEL_CACHE_ENABLE_BIT];
            fl = en && k[FMI_BIT];
            if (!fl) wbseen = 0;
            w = (i < 6) ? 1'b0 : r[0];
            c = (i < 6) ? 1'b1 : r[1];
            @(posedge mclk_in) begin tm <= (i < 6) | r[2]; tv <= (i < 6) | r[3]; td <= (i < 6) | r[4]; end
            lookup(w, c);
            e = exp_f(k, w, c, tm, tv, td);
            `CHK("lookup outcome", e, got)
            `CHK("pulse total", 8'($countones(e)), cnt)
            `CHK("cache enable", k[FIRST_LEVEL_CACHE_ENABLE_BIT] && c, kseen)
            wbn = wbn + 16'(e[0]);
            invn = invn + 16'(e[1]);
            if (e[0]) wbseen = 1;
            if (w && fl) incoh = 1;
            rd_reg(CACHE_CTL_OFF, rv); `CHK("ctl readback", k & CTL_WMASK, rv)
            rd_reg(STATUS_OFF, rv); `CHK("status", {4'h0, incoh, wbseen, fl, en}, rv)
        end
        wr_reg(STATUS_OFF, 8'h08);
        rd_reg(STATUS_OFF, rv); `CHK("status cleared", {4'h0, 1'b0, wbseen, fl, en}, rv)
        rd_reg(WB_CNT_LO_OFF, rv); `CHK("wb count lo", wbn[7:0], rv)
        rd_reg(WB_CNT_HI_OFF, rv); `CHK("wb count hi", wbn[15:8], rv)
        rd_reg(INV_CNT_LO_OFF, rv); `CHK("inv count lo", invn[7:0], rv)
        rd_reg(INV_CNT_HI_OFF, rv); `CHK("inv count hi", invn[15:8], rv)
        results();
    end
endmodule // tb_top
`default_nettype wire
